/* rtl/config_integrity_checker.sv */
// Readback-compare and cyclic self integrity scan of the configuration memory.
`timescale 1ns/1ns
module config_integrity_checker #(
    parameter int ADDR_W = 20,                       // Configuration address width.
    parameter int DATA_W = 16,                       // Parallel data bus width.
    parameter logic [19:0] MEM_LAST = 20'hfffff,     // Highest configuration byte address.
    parameter logic [19:0] CKSUM_ADDR = 20'h00000,   // Download checksum window address.
    parameter logic [19:0] RECUR_ADDR = 20'h00001    // Stored recurrent checksum address.
) (
    input wire logic sys_clk_i,                      // System clock, 10 MHz.
    input wire logic rst_i,                          // Asynchronous reset, active high.
    input wire logic run_phase_i,                    // Device is in run phase.
    input wire logic [2:0] mode_i,                   // Configuration mode code.
    input wire logic wide_bus_i,                     // Parallel bus is sixteen bits wide.
    input wire logic integrity_enable_bit_i,         // Self integrity scan enable.
    input wire logic continuous_clock_bit_i,         // Master link clock runs continuously.
    input wire logic config_clock_i,                 // Link clock pin input.
    input wire logic verify_request_n_i,             // Verify request pin, active low.
    input wire logic serial_select_n_i,              // Serial chip select pin, active low.
    input wire logic parallel_select_n_i,            // Parallel chip select pin, active low.
    input wire logic [DATA_W-1:0] config_data_i,     // Serial bit on bit 0, or parallel data.
    input wire logic [7:0] mem_rdata_i,              // Memory byte, the cycle after its address.
    output logic [ADDR_W-1:0] mem_addr_o,            // Configuration memory read address.
    output logic config_clock_o,                     // Link clock output in master mode.
    output logic config_clock_oe_n_o,                // Link clock output enable, active low.
    output logic [ADDR_W-1:0] config_address_out_o,  // External memory address in mode 6.
    output logic integrity_error_n_o,                // Open-drain error level, always low.
    output logic integrity_error_oe_n_o,             // Error pin enable, low pulls pin low.
    output logic compare_busy_o                      // Compare pass in progress.
);
    // One-hot pass states.
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_PRE = 7'h02,
        ST_SADDR = 7'h04,
        ST_EADDR = 7'h08,
        ST_DATA = 7'h10,
        ST_POST = 7'h20,
        ST_ABORT = 7'h40
    } pass_state_e;

    // Complete state of the block.
    typedef struct packed {
        pass_state_e state;          // Compare pass state.
        logic clk_s1;                // Link clock synchroniser, first stage.
        logic clk_s2;                // Link clock synchroniser, second stage.
        logic clk_p;                 // Previous synchronised link clock.
        logic vrq_s1;                // Verify request synchroniser stages.
        logic vrq_s2;
        logic vrq_p;                 // Previous synchronised verify request.
        logic ssel_s1;               // Serial select synchroniser stages.
        logic ssel_s2;
        logic psel_s1;               // Parallel select synchroniser stages.
        logic psel_s2;
        logic [DATA_W-1:0] dat_s1;   // Data synchroniser stages.
        logic [DATA_W-1:0] dat_s2;
        logic [2:0] div_cnt;         // Master clock divider count.
        logic config_clock;                  // Master clock output level.
        logic [7:0] shift;           // Serial byte assembly.
        logic [2:0] bit_cnt;         // Serial bit index.
        logic hi_pend;               // Upper byte of a wide word waits.
        logic [7:0] hi_byte;         // Upper byte of a wide word.
        logic byte_v;                // A stream byte is ready this cycle.
        logic [7:0] byte_val;        // The ready stream byte.
        logic [1:0] addr_cnt;        // Address bytes taken so far.
        logic [23:0] addr_acc;       // Address assembly, most significant first.
        logic [ADDR_W-1:0] stop;     // Window stop address.
        logic [ADDR_W-1:0] cur;      // Current compare address.
        logic [ADDR_W-1:0] mem_addr; // Memory read address.
        logic c_v1;                  // Compare pipeline valid, stage one and two.
        logic c_v2;
        logic [7:0] c_b1;            // Expected byte, stage one and two.
        logic [7:0] c_b2;
        logic cmp_err;               // Compare mismatch drives the pin.
        logic mm_arm;                // Mismatch countdown running.
        logic [1:0] mm_cnt;          // Edges left before mismatch drive.
        logic [1:0] ll_cnt;          // Edges left before protocol pulse.
        logic ll_low;                // Protocol error pulse active.
        logic [ADDR_W-1:0] scan_addr;// Scan read address.
        logic s_v1;                  // Scan pipeline valid, stage one and two.
        logic s_v2;
        logic s_ref1;                // Scan read is the reference byte.
        logic s_ref2;
        logic s_last1;               // Scan read is the last address.
        logic s_last2;
        logic [7:0] sum;             // Running recurrent checksum.
        logic [7:0] ref_byte;        // Stored recurrent checksum.
        logic scan_err;              // Sticky scan mismatch.
    } state_s;

    state_s q;
    state_s d;
    // Checksum step: rotate left and fold in the next byte.
    function automatic logic [7:0] cksum_step(input logic [7:0] acc, input logic [7:0] b);
        cksum_step = {acc[6:0], acc[7]} ^ b;
    endfunction
    // Next-state logic for the whole block.
    always_comb begin
        logic tick;
        logic master;
        logic serial;
        logic start_ok;
        logic scan_on;
        logic [ADDR_W-1:0] ea;
        d = q;
        ea = '0;
        tick = 1'b0;
        start_ok = 1'b0;
        master = (mode_i == cfg_check_pkg::MODE_MASTER_SERIAL);
        serial = master || (mode_i == cfg_check_pkg::MODE_SLAVE_SERIAL)
                 || (mode_i == cfg_check_pkg::MODE_SLAVE_SERIAL_UP);
        // The scan only runs when enabled, and in master mode only with a free running clock.
        scan_on = integrity_enable_bit_i && run_phase_i && (!master || continuous_clock_bit_i);
        // Pin inputs pass two flip-flops before use.
        d.clk_s1 = config_clock_i;
        d.clk_s2 = q.clk_s1;
        d.clk_p = q.clk_s2;
        d.vrq_s1 = verify_request_n_i;
        d.vrq_s2 = q.vrq_s1;
        d.vrq_p = q.vrq_s2;
        d.ssel_s1 = serial_select_n_i;
        d.ssel_s2 = q.ssel_s1;
        d.psel_s1 = parallel_select_n_i;
        d.psel_s2 = q.psel_s1;
        d.dat_s1 = config_data_i;
        d.dat_s2 = q.dat_s1;
        // The master clock runs during a pass, or in run phase with the continuous bit.
        if (master && ((q.state != ST_IDLE) || (continuous_clock_bit_i && run_phase_i))) begin
            if (q.div_cnt == 3'(cfg_check_pkg::MASTER_HALF_CYCLES - 1)) begin
                d.div_cnt = '0;
                d.config_clock = ~q.config_clock;
                tick = ~q.config_clock;
            end else begin
                d.div_cnt = q.div_cnt + 3'h1;
            end
        end else if (!master) begin
            // Slaves rely on the outside party keeping the clock alive.
            tick = q.clk_s2 & ~q.clk_p;
        end
        // Default pipeline advance.
        d.byte_v = 1'b0;
        d.c_v1 = 1'b0;
        d.c_v2 = q.c_v1;
        d.c_b2 = q.c_b1;
        d.s_v1 = 1'b0;
        d.s_v2 = q.s_v1;
        d.s_ref2 = q.s_ref1;
        d.s_last2 = q.s_last1;
        // A pass starts on the falling verify request, with the select the mode demands.
        unique case (mode_i)
            cfg_check_pkg::MODE_SLAVE_SERIAL: start_ok = ~q.ssel_s2;
            cfg_check_pkg::MODE_SLAVE_PARALLEL: start_ok = ~q.psel_s2;
            default: start_ok = 1'b1;
        endcase
        // Byte assembly from the link during a pass.
        if ((q.state != ST_IDLE) && (q.state != ST_ABORT)) begin
            if (tick && serial) begin
                d.shift = {q.shift[6:0], q.dat_s2[0]};
                d.bit_cnt = q.bit_cnt + 3'h1;
                if (q.bit_cnt == cfg_check_pkg::SERIAL_LAST_BIT) begin
                    d.byte_v = 1'b1;
                    d.byte_val = {q.shift[6:0], q.dat_s2[0]};
                end
            end else if (tick) begin
                // Low byte first, the upper byte follows a cycle later.
                d.byte_v = 1'b1;
                d.byte_val = q.dat_s2[7:0];
                d.hi_pend = wide_bus_i;
                d.hi_byte = q.dat_s2[DATA_W-1:8];
            end else if (q.hi_pend) begin
                d.byte_v = 1'b1;
                d.byte_val = q.hi_byte;
                d.hi_pend = 1'b0;
            end
        end
        // Pass sequencing.
        unique case (q.state)
            ST_IDLE: begin
                if (run_phase_i && ~q.vrq_s2 && q.vrq_p && start_ok) begin
                    d.state = ST_PRE;
                    d.cmp_err = 1'b0;
                    d.mm_arm = 1'b0;
                    d.bit_cnt = '0;
                    d.hi_pend = 1'b0;
                end
            end
            ST_PRE: begin
                if (q.byte_v && (q.byte_val == cfg_check_pkg::PREAMBLE)) begin
                    d.state = ST_SADDR;
                    d.addr_cnt = '0;
                end else if (q.byte_v) begin
                    d.state = ST_ABORT;
                    d.ll_cnt = cfg_check_pkg::PROTOCOL_EDGES;
                end
            end
            ST_SADDR, ST_EADDR: begin
                if (q.byte_v) begin
                    d.addr_acc = {q.addr_acc[15:0], q.byte_val};
                    d.addr_cnt = q.addr_cnt + 2'h1;
                    if (q.addr_cnt == cfg_check_pkg::ADDR_BYTES - 2'h1) begin
                        d.addr_cnt = '0;
                        ea = d.addr_acc[ADDR_W-1:0];
                        if (q.state == ST_SADDR) begin
                            d.cur = d.addr_acc[ADDR_W-1:0];
                            d.state = ST_EADDR;
                            // Bits above the address range mark a corrupted start.
                            if (d.addr_acc[23:ADDR_W] != '0 || ea > MEM_LAST) begin
                                d.state = ST_ABORT;
                                d.ll_cnt = cfg_check_pkg::PROTOCOL_EDGES;
                            end
                        end else begin
                            d.stop = ea;
                            d.state = ST_DATA;
                            if (d.addr_acc[23:ADDR_W] != '0 || ea > MEM_LAST || ea < q.cur) begin
                                d.state = ST_ABORT;
                                d.ll_cnt = cfg_check_pkg::PROTOCOL_EDGES;
                            end
                        end
                    end
                end
            end
            ST_DATA: begin
                if (q.byte_v) begin
                    // Read the location and queue the expected byte; nothing is written.
                    d.mem_addr = q.cur;
                    d.c_v1 = (q.cur != CKSUM_ADDR);
                    d.c_b1 = q.byte_val;
                    if (q.cur == q.stop) begin
                        d.state = ST_POST;
                    end else begin
                        d.cur = q.cur + ADDR_W'(1);
                    end
                end
            end
            ST_POST: begin
                if (q.byte_v) begin
                    d.state = ST_IDLE;
                    if (q.byte_val != cfg_check_pkg::POSTAMBLE) begin
                        d.state = ST_ABORT;
                        d.ll_cnt = cfg_check_pkg::PROTOCOL_EDGES;
                    end
                end
            end
            ST_ABORT: begin
                // Count a few link clocks, then pulse the pin low for one period.
                if (tick && q.ll_low) begin
                    d.ll_low = 1'b0;
                    d.state = ST_IDLE;
                end else if (tick && (q.ll_cnt == 2'h1)) begin
                    d.ll_low = 1'b1;
                    d.ll_cnt = '0;
                end else if (tick) begin
                    d.ll_cnt = q.ll_cnt - 2'h1;
                end
            end
        endcase
        // Compare the memory byte with the expected one; only the first mismatch counts.
        if (q.c_v2 && (mem_rdata_i != q.c_b2) && !q.mm_arm && !q.cmp_err) begin
            d.mm_arm = 1'b1;
            d.mm_cnt = cfg_check_pkg::MISMATCH_EDGES;
        end
        if (q.mm_arm && tick) begin
            d.mm_cnt = q.mm_cnt - 2'h1;
            if (q.mm_cnt == 2'h1) begin
                d.cmp_err = 1'b1;
                d.mm_arm = 1'b0;
            end
        end
        if (!scan_on || (q.state != ST_IDLE)) begin
            // A pass or a disable restarts the scan from the bottom.
            d.scan_addr = '0;
            d.sum = '0;
            d.s_v2 = 1'b0;
        end else if (tick) begin
            d.mem_addr = q.scan_addr;
            d.s_v1 = 1'b1;
            d.s_ref1 = (q.scan_addr == RECUR_ADDR);
            d.s_last1 = (q.scan_addr == MEM_LAST);
            d.scan_addr = (q.scan_addr == MEM_LAST) ? '0 : q.scan_addr + ADDR_W'(1);
        end
        if (q.s_v2 && scan_on && (q.state == ST_IDLE)) begin
            if (q.s_ref2) begin
                d.ref_byte = mem_rdata_i;
            end else begin
                d.sum = cksum_step(q.sum, mem_rdata_i);
            end
            if (q.s_last2) begin
                // Compare against the reference, then start the next round.
                d.sum = '0;
                if ((q.s_ref2 ? q.sum : cksum_step(q.sum, mem_rdata_i)) != d.ref_byte) begin
                    d.scan_err = 1'b1;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            q.state <= ST_IDLE;
            q.vrq_s1 <= 1'b1;
            q.vrq_s2 <= 1'b1;
            q.vrq_p <= 1'b1;
            q.ssel_s1 <= 1'b1;
            q.ssel_s2 <= 1'b1;
            q.psel_s1 <= 1'b1;
            q.psel_s2 <= 1'b1;
        end else begin
            q <= d;
        end
    end
    // Outputs; the error pin floats high unless one of the three causes pulls it.
    assign mem_addr_o = q.mem_addr;
    assign config_clock_o = q.config_clock;
    assign config_clock_oe_n_o = (mode_i != cfg_check_pkg::MODE_MASTER_SERIAL);
    assign config_address_out_o = q.cur;
    assign integrity_error_n_o = 1'b0;
    assign integrity_error_oe_n_o = ~(q.scan_err | q.cmp_err | q.ll_low);
    assign compare_busy_o = (q.state != ST_IDLE);
endmodule

/* shared/cfg_check_pkg.sv */
// Constants shared by the configuration integrity checker.
package cfg_check_pkg;
    // Framing bytes of a download stream.
    localparam logic [7:0] PREAMBLE = 8'hb7;
    localparam logic [7:0] POSTAMBLE = 8'he7;
    // Configuration mode codes.
    localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
    localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h1;
    localparam logic [2:0] MODE_SLAVE_SERIAL_UP = 3'h7;
    localparam logic [2:0] MODE_SLAVE_PARALLEL = 3'h2;
    localparam logic [2:0] MODE_SLAVE_PARALLEL_UP = 3'h6;
    // Link clock edges from an offending byte to the error drive.
    localparam logic [1:0] MISMATCH_EDGES = 2'h2;
    // Link clock edges from a protocol error to the error pulse.
    localparam logic [1:0] PROTOCOL_EDGES = 2'h3;
    // Number of address bytes in a window start or stop field.
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    // Last bit index of a serial byte.
    localparam logic [2:0] SERIAL_LAST_BIT = 3'h7;
    // Clock period in ns and half period of the master link clock in ns.
    localparam int SYS_CLK_NS = 100;
    localparam int MASTER_HALF_NS = 400;
    localparam int MASTER_HALF_CYCLES = (MASTER_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
endpackage

/* test/cfg_source_model.sv */
// Behavioural configuration source: link clock and parallel byte stream.
`timescale 1ns/1ns
module cfg_source_model (
    input wire logic run_i, // Link clock runs while high.
    input wire logic wide_i, // Two stream bytes per link edge while high.
    output logic clk_o, // Link clock to the device.
    output logic [15:0] data_o // Parallel data to the device.
);
    logic [7:0] pending[$]; // Bytes waiting to go out.
    logic [7:0] last_q = 8'h00; // Last byte shown.
    // Queue one byte for the stream.
    task automatic put(input logic [7:0] b);
        pending.push_back(b);
    endtask
    // The clock never stops in run phase, since the scan depends on it.
    initial begin
        clk_o = 1'b0;
        data_o = 16'h0000;
        #37;
        forever begin
            #400;
            if (run_i) clk_o = ~clk_o;
            // Data moves on the falling edge so it is settled at the rising one.
            if (run_i && !clk_o) begin
                // Idle lines show a changing pattern, never a stale byte.
                if (pending.size() > 0) last_q = pending.pop_front();
                else last_q = ~last_q;
                // A wide word carries the next byte in its upper half.
                if (wide_i && pending.size() > 0) data_o = {pending.pop_front(), last_q};
                else data_o = {~last_q, last_q};
            end
        end
    end
endmodule

/* test/config_integrity_checker_assertions.sv */
// Concurrent checks on the ports of the configuration integrity checker.
`timescale 1ns/1ns
module config_integrity_checker_assertions #(
    parameter logic [19:0] MEM_LAST = 20'hfffff // Highest configuration byte address.
) (
    input wire logic sys_clk_i, // System clock.
    input wire logic rst_i, // Reset, active high.
    input wire logic run_phase_i, // Run phase.
    input wire logic [2:0] mode_i, // Mode code.
    input wire logic continuous_clock_bit_i, // Free running master clock.
    input wire logic verify_request_n_i, // Verify request, active low.
    input wire logic parallel_select_n_i, // Parallel select, active low.
    input wire logic [19:0] mem_addr_o, // Memory read address.
    input wire logic config_clock_o, // Master link clock.
    input wire logic config_clock_oe_n_o, // Link clock enable, active low.
    input wire logic integrity_error_n_o, // Error pin level.
    input wire logic integrity_error_oe_n_o, // Error pin enable, active low.
    input wire logic compare_busy_o // Compare pass running.
);
    // Every check samples on the system clock and is silenced during reset.
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    chk_pin_open_drain: assert property (integrity_error_n_o == 1'b0)
        else $error("Error pin drives a high level.");
    chk_clock_drive: assert property (config_clock_oe_n_o == (mode_i != 3'h0))
        else $error("Link clock drive does not follow the mode.");
    chk_clock_period: assert property ((mode_i == 3'h0 && run_phase_i && continuous_clock_bit_i
        && $changed(config_clock_o)) |=> $stable(config_clock_o)[*3]) else $error("Master clock toggles too soon.");
    chk_start_in_run: assert property ($rose(compare_busy_o) |-> run_phase_i)
        else $error("Pass started outside run phase.");
    chk_start_request: assert property ($rose(compare_busy_o) |-> !verify_request_n_i)
        else $error("Pass started without a verify request.");
    chk_select_mode2: assert property (($rose(compare_busy_o) && mode_i == 3'h2) |-> !parallel_select_n_i)
        else $error("Parallel pass started without select.");
    chk_idle_no_start: assert property (verify_request_n_i[*4] |-> !$rose(compare_busy_o))
        else $error("Pass started while request was high.");
    chk_addr_bound: assert property (mem_addr_o <= MEM_LAST)
        else $error("Memory address beyond the last byte.");
    chk_mismatch_hold: assert property ((compare_busy_o && $fell(integrity_error_oe_n_o))
        |=> !integrity_error_oe_n_o[*6]) else $error("Mismatch error released early.");
    chk_reset_release: assert property ($fell(rst_i) |-> integrity_error_oe_n_o)
        else $error("Error pin not released by reset.");
endmodule
bind config_integrity_checker config_integrity_checker_assertions #(.MEM_LAST(MEM_LAST)) checker_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .run_phase_i(run_phase_i), .mode_i(mode_i),
    .continuous_clock_bit_i(continuous_clock_bit_i), .verify_request_n_i(verify_request_n_i),
    .parallel_select_n_i(parallel_select_n_i), .mem_addr_o(mem_addr_o), .config_clock_o(config_clock_o),
    .config_clock_oe_n_o(config_clock_oe_n_o), .integrity_error_n_o(integrity_error_n_o),
    .integrity_error_oe_n_o(integrity_error_oe_n_o), .compare_busy_o(compare_busy_o));

/* test/config_integrity_checker_test.sv */
// Self-checking bench for the configuration integrity checker.
`timescale 1ns/1ns
module config_integrity_checker_test;
    localparam logic [19:0] LAST = 20'h0000f; // Short memory keeps each sweep brief.
    logic sys_clk_i = 1'b0, rst_i = 1'b1, run_phase_i = 1'b1, integrity_enable_bit_i = 1'b0;
    logic continuous_clock_bit_i = 1'b0, verify_request_n_i = 1'b1, parallel_select_n_i = 1'b1;
    logic wide_bus_i = 1'b0, serial_select_n_i = 1'b1; // Bus width and serial select.
    logic [2:0] mode_i = cfg_check_pkg::MODE_SLAVE_PARALLEL; // Configuration mode.
    logic config_clock_i, config_clock_o, config_clock_oe_n_o, clk_seen; // Link clock wires.
    logic integrity_error_n_o, integrity_error_oe_n_o, compare_busy_o; // Status outputs.
    logic [15:0] config_data_i; // Stream from the source model.
    logic [7:0] mem_rdata_i = 8'h00; // Memory answer.
    logic [19:0] mem_addr_o, config_address_out_o; // Memory and external addresses.
    logic [7:0] mem [0:15]; // Loaded configuration bytes.
    logic exp_q[$]; // Expected error enable levels.
    event probe; // Raised when a result is due.
    int seed = 43, mismatches = 0, check_count = 0;
    config_integrity_checker #(.MEM_LAST(LAST)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .run_phase_i(run_phase_i), .mode_i(mode_i), .wide_bus_i(wide_bus_i),
        .integrity_enable_bit_i(integrity_enable_bit_i), .continuous_clock_bit_i(continuous_clock_bit_i),
        .config_clock_i(config_clock_i), .verify_request_n_i(verify_request_n_i),
        .serial_select_n_i(serial_select_n_i),
        .parallel_select_n_i(parallel_select_n_i), .config_data_i(config_data_i), .mem_rdata_i(mem_rdata_i),
        .mem_addr_o(mem_addr_o), .config_clock_o(config_clock_o), .config_clock_oe_n_o(config_clock_oe_n_o),
        .config_address_out_o(config_address_out_o), .integrity_error_n_o(integrity_error_n_o),
        .integrity_error_oe_n_o(integrity_error_oe_n_o), .compare_busy_o(compare_busy_o));
    cfg_source_model src (.run_i(1'b1), .wide_i(wide_bus_i), .clk_o(config_clock_i), .data_o(config_data_i));
    // System clock, 100 ns period.
    initial forever #50 sys_clk_i = ~sys_clk_i;
    // The memory answers on the clock edge after it is addressed.
    always @(posedge sys_clk_i) begin
        mem_rdata_i <= mem[mem_addr_o[3:0]];
    end
    // Each probe takes the oldest expected level and compares it with the pin enable.
    always @(probe) check("error enable", {7'h00, integrity_error_oe_n_o}, {7'h00, exp_q.pop_front()});
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", what, want, seen);
        end
    endtask
    // Inputs always move 1 ns after the rising edge.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic expect_err(input logic v);
        exp_q.push_back(v);
        -> probe;
    endtask
    // Bounded wait for the error enable to reach a level.
    task automatic wait_err(input logic v, input int n);
        for (int i = 0; i < n && integrity_error_oe_n_o !== v; i++) tick(1);
    endtask
    // Address fields are three bytes, upper ones zero.
    task automatic put_addr(input logic [7:0] lo);
        src.put(8'h00);
        src.put(8'h00);
        src.put(lo);
    endtask
    // Rotate-and-xor over every byte except the stored reference.
    function automatic logic [7:0] scan_sum();
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 0; i < 16; i++) if (i != 1) acc = {acc[6:0], acc[7]} ^ mem[i];
        return acc;
    endfunction
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Main sequence: compare passes of five kinds, then the scan, then reset.
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 8'($random(seed));
        mem[1] = scan_sum();
        tick(10);
        rst_i = 1'b0;
        tick(4);
        expect_err(1'b1);
        // Outside run phase a request is ignored, and mode 1 also needs its serial select.
        run_phase_i = 1'b0;
        mode_i = cfg_check_pkg::MODE_SLAVE_SERIAL;
        for (int s = 0; s < 3; s++) begin
            serial_select_n_i = (s == 1);
            verify_request_n_i = 1'b0;
            tick(8);
            check("busy", {7'h00, compare_busy_o}, {7'h00, s == 2});
            verify_request_n_i = 1'b1;
            serial_select_n_i = 1'b1;
            run_phase_i = 1'b1;
            tick(6);
        end
        // The idle pattern never forms a preamble, so the serial pass aborts.
        wait_err(1'b0, 200);
        expect_err(1'b0);
        tick(16);
        // Pass kinds: good on the wide bus, data mismatch, bad preamble, stop before start, bad postamble.
        for (int k = 0; k < 5; k++) begin
            mode_i = k[0] ? cfg_check_pkg::MODE_SLAVE_PARALLEL_UP : cfg_check_pkg::MODE_SLAVE_PARALLEL;
            wide_bus_i = (k == 0);
            // Queue the stream on a falling link edge, so the first byte waits for the pass.
            @(negedge config_clock_i);
            src.put((k == 2) ? 8'h5a : cfg_check_pkg::PREAMBLE);
            put_addr(8'h02);
            put_addr((k == 3) ? 8'h01 : 8'h05);
            for (int a = 2; a <= ((k == 3) ? 1 : 5); a++) src.put(mem[a] ^ ((k == 1 && a == 4) ? 8'h10 : 8'h00));
            src.put((k == 4) ? 8'h66 : cfg_check_pkg::POSTAMBLE);
            // Start between two rising link edges, once the earlier one has been sampled.
            @(posedge config_clock_i);
            tick(4);
            parallel_select_n_i = k[0];
            verify_request_n_i = 1'b0;
            tick(6);
            check("busy", {7'h00, compare_busy_o}, 8'h01);
            expect_err(1'b1);
            wait_err(1'b0, (k == 0) ? 200 : 300);
            expect_err(k == 0);
            tick(16);
            expect_err(k != 1);
            tick(100);
            if (k < 2) check("busy", {7'h00, compare_busy_o}, 8'h00);
            if (k < 2) check("address", config_address_out_o[7:0], 8'h05);
            verify_request_n_i = 1'b1;
            parallel_select_n_i = 1'b1;
            tick(6);
        end
        mode_i = cfg_check_pkg::MODE_SLAVE_PARALLEL;
        integrity_enable_bit_i = 1'b1;
        tick(600);
        expect_err(1'b1);
        integrity_enable_bit_i = 1'b0;
        mem[7] = mem[7] ^ 8'h04;
        tick(400);
        expect_err(1'b1);
        integrity_enable_bit_i = 1'b1;
        wait_err(1'b0, 600);
        expect_err(1'b0);
        mem[7] = mem[7] ^ 8'h04;
        tick(300);
        expect_err(1'b0);
        mode_i = cfg_check_pkg::MODE_MASTER_SERIAL;
        continuous_clock_bit_i = 1'b1;
        tick(2);
        clk_seen = config_clock_o;
        check("clock enable", {7'h00, config_clock_oe_n_o}, 8'h00);
        tick(4);
        check("master clock", {7'h00, config_clock_o}, {7'h00, ~clk_seen});
        rst_i = 1'b1;
        tick(2);
        rst_i = 1'b0;
        tick(3);
        expect_err(1'b1);
        tick(2);
        stop_test();
    end
    // Cut a hang short well beyond the expected run length.
    initial begin
        #4000000;
        mismatches++;
        stop_test();
    end
endmodule
